// file: src/module_mgmt_status_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_defs.svh"
module module_mgmt_status_timing
  import mgmt_pkg::*;
#(
  parameter int     N_FLAGS    = 8,
  parameter count_t INIT_CYC   = `INIT_CYCLES,
  parameter count_t PDOWN_CYC  = `PDOWN_ON_CYCLES,
  parameter count_t WAKE_CYC   = `PDOWN_OFF_CYCLES
) (
  input  wire logic               REF_CLK,             // 40 MHz clock
  input  wire logic               RSTN,                // sync reset, low
  input  wire logic               MODULE_RESET_N,      // reset pin, async
  input  wire logic               MODULE_SELECT_N,     // select pin, async
  input  wire logic               LOW_POWER_REQUEST,   // low power pin
  input  wire logic [N_FLAGS-1:0] FLAG_COND,           // flag conditions
  input  wire logic [N_FLAGS-1:0] FLAG_MASK,           // mask bits
  input  wire logic [N_FLAGS-1:0] FLAG_READ_CLEAR,     // read-clear pulses
  input  wire logic               POWER_DOWN,          // power-down bit
  input  wire logic               POWER_OVERRIDE,      // power-override bit
  output logic [N_FLAGS-1:0]      FLAG_STATUS,         // latched flags
  output logic                    ATTENTION_REQUEST_N, // attention, low
  output logic                    BUS_ENABLE,          // serial answers
  output logic                    LOW_POWER,           // low power level
  output logic                    DATA_NOT_READY,      // byte 2 bit 0
  output logic                    PRESENCE_N           // module present
);
  // ----------------------------------------------------------------
  // pin synchronisers: 3 stages, change when stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] sel_sync_reg;
  logic [2:0] lpm_sync_reg;
  logic [2:0] mrst_sync_reg;
  logic       sel_reg;
  logic       lpm_reg;
  logic       mrst_reg;

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      sel_sync_reg  <= 3'h7;
      lpm_sync_reg  <= 3'h0;
      mrst_sync_reg <= 3'h7;
    end
    else
    begin
      sel_sync_reg  <= {sel_sync_reg[1:0], MODULE_SELECT_N};
      lpm_sync_reg  <= {lpm_sync_reg[1:0], LOW_POWER_REQUEST};
      mrst_sync_reg <= {mrst_sync_reg[1:0], MODULE_RESET_N};
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      sel_reg  <= 1'b1;
      lpm_reg  <= 1'b0;
      mrst_reg <= 1'b1;
    end
    else
    begin
      if (sel_sync_reg[1] == sel_sync_reg[2])
        sel_reg <= sel_sync_reg[2];
      if (lpm_sync_reg[1] == lpm_sync_reg[2])
        lpm_reg <= lpm_sync_reg[2];
      if (mrst_sync_reg[1] == mrst_sync_reg[2])
        mrst_reg <= mrst_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // module reset pin: pulses shorter than the minimum are filtered
  // ----------------------------------------------------------------
  localparam count_t RST_MIN = count_t'(`RESET_MIN_CYCLES);
  count_t rlow_cnt_reg;
  logic   mod_reset_reg;

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      rlow_cnt_reg  <= '0;
      mod_reset_reg <= 1'b0;
    end
    else if (mrst_reg)
    begin
      rlow_cnt_reg  <= '0;
      mod_reset_reg <= 1'b0;
    end
    else if (rlow_cnt_reg >= RST_MIN)
      mod_reset_reg <= 1'b1;
    else
      rlow_cnt_reg <= rlow_cnt_reg + 32'h0000_0001;
  end

  wire logic soft_rst_n = RSTN & ~mod_reset_reg;

  // ----------------------------------------------------------------
  // bus select gating: sync latency of a few cycles is far below 100 us
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!soft_rst_n)
      BUS_ENABLE <= 1'b0;
    else
      BUS_ENABLE <= ~sel_reg;
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  pwr_state_e state_reg;
  pwr_state_e state_next;
  count_t     tmr_reg;
  count_t     tmr_next;
  logic       pd_req;

  assign pd_req = POWER_DOWN | POWER_OVERRIDE;

  always_comb
  begin
    state_next = state_reg;
    tmr_next   = tmr_reg + 32'h0000_0001;
    case (state_reg)
      ST_INIT:
        if (tmr_reg >= INIT_CYC - 32'h0000_0001)
        begin
          state_next = ST_READY;
          tmr_next   = '0;
        end
      ST_READY:
      begin
        tmr_next = '0;
        if (pd_req || lpm_reg)
          state_next = ST_LOWPWR;
      end
      ST_LOWPWR:
      begin
        tmr_next = '0;
        if (!pd_req && !lpm_reg)
          state_next = ST_WAKE;
      end
      ST_WAKE:
        if (pd_req || lpm_reg)
        begin
          state_next = ST_LOWPWR;
          tmr_next   = '0;
        end
        else if (tmr_reg >= WAKE_CYC - 32'h0000_0001)
        begin
          state_next = ST_READY;
          tmr_next   = '0;
        end
      default:
      begin
        state_next = ST_INIT;
        tmr_next   = '0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!soft_rst_n)
    begin
      state_reg <= ST_INIT;
      tmr_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
    end
  end

  // low power entered at once from ready or wake (requests wait out init), well inside 100 us / 100 ms
  always_ff @(posedge REF_CLK)
  begin
    if (!soft_rst_n)
      LOW_POWER <= 1'b0;
    else
      LOW_POWER <= (state_next == ST_LOWPWR);
  end

  // ----------------------------------------------------------------
  // data-not-ready and its ready event
  // ----------------------------------------------------------------
  logic ready_evt;

  always_ff @(posedge REF_CLK)
  begin
    if (!soft_rst_n)
      DATA_NOT_READY <= 1'b1;
    else if (state_next == ST_READY)
      DATA_NOT_READY <= 1'b0;
    else if (state_next == ST_INIT || state_next == ST_WAKE)
      DATA_NOT_READY <= 1'b1;
  end

  // ready transition becomes a latched flag in the top slot of the bank
  assign ready_evt = (state_next == ST_READY) && (state_reg != ST_READY);

  // ----------------------------------------------------------------
  // flag bank; slot N_FLAGS is the ready flag, unmaskable
  // ----------------------------------------------------------------
  flag_bank_if #(.N(N_FLAGS + 1)) fbi ();

  assign fbi.cond     = {ready_evt, FLAG_COND};
  assign fbi.mask     = {1'b0, FLAG_MASK};
  assign fbi.rd_clear = {FLAG_READ_CLEAR[0], FLAG_READ_CLEAR};

  flag_bank #(.N(N_FLAGS + 1)) u_flags (
    .clk   (REF_CLK),
    .rst_n (soft_rst_n),
    .fb    (fbi)
  );

  always_ff @(posedge REF_CLK)
  begin
    if (!soft_rst_n)
    begin
      FLAG_STATUS         <= '0;
      ATTENTION_REQUEST_N <= 1'b1;
    end
    else
    begin
      FLAG_STATUS         <= fbi.flags[N_FLAGS-1:0];
      ATTENTION_REQUEST_N <= ~fbi.attn;
    end
  end

  assign PRESENCE_N = 1'b0;
endmodule : module_mgmt_status_timing
`default_nettype wire

// file: src/mgmt_defs.svh
// Functional notes
// - any interrupting condition drives attention output low within 200 ms.
// - after clear-on-read of a flag, release attention within 500 us.
// - loss-of-signal, transmit fault and other flags are clear-on-read latches.
// - receive loss-of-signal sets its flag and attention within 100 ms.
// - any flag condition sets its flag and attention within 200 ms.
// - setting a mask stops that flag asserting attention within 100 ms.
// - clearing a mask resumes attention for that flag within 100 ms.
// - serial bus answers within 100 us after module select goes low.
// - serial bus stops answering within 100 us after select goes high.
// - power-down bit set enters low power within 100 ms; during init the code enters low power only when init ends.
// - power-down bit cleared returns fully functional within 300 ms.
// - fully functional: data-not-ready bit 0 of byte 2 clears, attention set.
// - low-power request high enters low power within 100 us; during init the code enters low power only when init ends.
// - reset held over 2 us; fully functional within 2000 ms after release.
// - within 2000 ms of power-on, data-not-ready clears and attention set.
`ifndef MGMT_DEFS_SVH
`define MGMT_DEFS_SVH
`define CLK_MHZ          40
`define INIT_TIME_MS     2000
`define INIT_CYCLES      (`INIT_TIME_MS * 1000 * `CLK_MHZ)
`define PDOWN_ON_MS      100
`define PDOWN_ON_CYCLES  (`PDOWN_ON_MS * 1000 * `CLK_MHZ)
`define PDOWN_OFF_MS     300
`define PDOWN_OFF_CYCLES (`PDOWN_OFF_MS * 1000 * `CLK_MHZ)
`define SEL_TIME_US      100
`define SEL_CYCLES       (`SEL_TIME_US * `CLK_MHZ)
`define LPM_TIME_US      100
`define LPM_CYCLES       (`LPM_TIME_US * `CLK_MHZ)
`define RESET_MIN_US     2
`define RESET_MIN_CYCLES (`RESET_MIN_US * `CLK_MHZ)
`define NOT_READY_BIT    0
`define NOT_READY_BYTE   2
`endif

// file: src/mgmt_pkg.sv
package mgmt_pkg;
  typedef enum logic [1:0] {ST_INIT, ST_READY, ST_LOWPWR, ST_WAKE} pwr_state_e;
  typedef logic [31:0] count_t;
endpackage : mgmt_pkg

// file: src/flag_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flag_bank_if #(parameter int N = 8);
  logic [N-1:0] cond;
  logic [N-1:0] mask;
  logic [N-1:0] rd_clear;
  logic [N-1:0] flags;
  logic         attn;
  modport bank (input cond, input mask, input rd_clear,
                output flags, output attn);
  modport ctl  (output cond, output mask, output rd_clear,
                input flags, input attn);
endinterface : flag_bank_if
`default_nettype wire

// file: src/flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
  parameter int N = 8
) (
  input  wire logic  clk,    // system clock
  input  wire logic  rst_n,  // sync reset
  flag_bank_if.bank  fb      // flag bank carrier
);
  import mgmt_pkg::*;
  logic [N-1:0] flag_reg;
  logic         attn_reg;

  // ----------------------------------------------------------------
  // per-flag sticky latch
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_flag
      // set wins over a clear-on-read in the same cycle
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          flag_reg[i] <= 1'b0;
        else if (fb.cond[i])
          flag_reg[i] <= 1'b1;
        else if (fb.rd_clear[i])
          flag_reg[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      attn_reg <= 1'b0;
    else
      attn_reg <= |(flag_reg & ~fb.mask);
  end

  assign fb.flags = flag_reg;
  assign fb.attn  = attn_reg;
endmodule : flag_bank
`default_nettype wire

// file: verif/mgmt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_monitor
  import mgmt_pkg::*;
#(
  parameter int     N_FLAGS  = 8,
  parameter count_t INIT_CYC = 100,
  parameter count_t WAKE_CYC = 50
) (
  input wire logic               REF_CLK,             // clock
  input wire logic               RSTN,                // reset
  input wire logic               MODULE_RESET_N,      // reset pin
  input wire logic               MODULE_SELECT_N,     // select
  input wire logic [N_FLAGS-1:0] FLAG_COND,           // conditions
  input wire logic [N_FLAGS-1:0] FLAG_MASK,           // masks
  input wire logic [N_FLAGS-1:0] FLAG_READ_CLEAR,     // reads
  input wire logic [N_FLAGS-1:0] FLAG_STATUS,         // flags
  input wire logic               ATTENTION_REQUEST_N, // attention
  input wire logic               BUS_ENABLE,          // bus on
  input wire logic               LOW_POWER,           // low power
  input wire logic               DATA_NOT_READY       // not ready
);
  count_t wait_reg;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // low power and the reset pin restart the init wait
  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN || !MODULE_RESET_N || LOW_POWER || !DATA_NOT_READY)
      wait_reg <= '0;
    else
      wait_reg <= wait_reg + 1;
  end
  sequence s_raise;
    (FLAG_COND[2] && !FLAG_MASK[2]) ##1 !FLAG_MASK[2] [*2];
  endsequence
  sequence s_clear_all;
    (&FLAG_READ_CLEAR && FLAG_COND == '0) ##1 (FLAG_COND == '0) [*3];
  endsequence
  a_flag_latch: assert property (FLAG_COND[1] |-> ##[1:2] FLAG_STATUS[1])
    else $error("flag not latched");
  a_attn_raise: assert property (s_raise |=> !ATTENTION_REQUEST_N)
    else $error("attention late");
  a_attn_hold: assert property (((FLAG_STATUS & ~FLAG_MASK) != '0) [*3]
    |-> !ATTENTION_REQUEST_N) else $error("attention dropped");
  a_attn_release: assert property (s_clear_all |-> ATTENTION_REQUEST_N)
    else $error("attention held");
  a_ready_attn: assert property ($fell(DATA_NOT_READY) |-> ##[0:2]
    !ATTENTION_REQUEST_N) else $error("ready without attention");
  a_ready_time: assert property (wait_reg <= INIT_CYC + WAKE_CYC + 16)
    else $error("not ready too long");
  a_bus_on: assert property ($fell(MODULE_SELECT_N) |-> ##[1:8] BUS_ENABLE)
    else $error("bus not answering");
  a_bus_off: assert property ($rose(MODULE_SELECT_N) |-> ##[1:8] !BUS_ENABLE)
    else $error("bus still answering");
endmodule : mgmt_monitor
bind module_mgmt_status_timing mgmt_monitor #(.N_FLAGS(N_FLAGS),
  .INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC)) mon_u (.REF_CLK(REF_CLK),
  .RSTN(RSTN), .MODULE_RESET_N(MODULE_RESET_N),
  .MODULE_SELECT_N(MODULE_SELECT_N), .FLAG_COND(FLAG_COND),
  .FLAG_MASK(FLAG_MASK), .FLAG_READ_CLEAR(FLAG_READ_CLEAR),
  .FLAG_STATUS(FLAG_STATUS), .ATTENTION_REQUEST_N(ATTENTION_REQUEST_N),
  .BUS_ENABLE(BUS_ENABLE), .LOW_POWER(LOW_POWER),
  .DATA_NOT_READY(DATA_NOT_READY));
`default_nettype wire

// file: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,        // clock
  input  wire logic       reset_req,  // reset the module
  input  wire logic [7:0] read_req,   // flags to read
  output logic            mod_rst_n,  // reset pin
  output logic [7:0]      read_clear  // read done pulse
);
  int         hold_reg = 0;
  logic [7:0] rc_reg   = '0;
  // a read completes on the falling edge after its stop bit
  always @(negedge clk)
  begin
    rc_reg   <= read_req;
    hold_reg <= reset_req ? 90 : (hold_reg > 0 ? hold_reg - 1 : 0);
  end
  assign read_clear = rc_reg;
  // 90 cycles keeps the pin low past the minimum pulse
  assign mod_rst_n = (hold_reg == 0);
endmodule : host_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] c; logic [7:0] m; logic a;} row_s;
  row_s rows [6] = '{'{8'h01, 8'h00, 1'b0}, '{8'h06, 8'h00, 1'b0},
    '{8'h04, 8'h04, 1'b1}, '{8'h0A, 8'h02, 1'b0}, '{8'hFF, 8'hFF, 1'b1},
    '{8'h80, 8'h7F, 1'b0}};
  logic       clk = 1'b0, rstn = 1'b0, sel_n = 1'b1, lp_req = 1'b0;
  logic       pdown = 1'b0, povr = 1'b0, reset_req = 1'b0;
  logic [7:0] cond = '0, mask = '0, read_req = '0, status, rclr;
  logic       attn_n, bus_en, low_pwr, dnr, mrst_n, pres_n;
  int         miscompares = 0, check_count = 0;
  always #12.5 clk = ~clk;
  module_mgmt_status_timing #(.INIT_CYC(100), .WAKE_CYC(50)) dut_u (
    .REF_CLK(clk), .RSTN(rstn), .MODULE_RESET_N(mrst_n),
    .MODULE_SELECT_N(sel_n), .LOW_POWER_REQUEST(lp_req),
    .FLAG_COND(cond), .FLAG_MASK(mask), .FLAG_READ_CLEAR(rclr),
    .POWER_DOWN(pdown), .POWER_OVERRIDE(povr), .FLAG_STATUS(status),
    .ATTENTION_REQUEST_N(attn_n), .BUS_ENABLE(bus_en),
    .LOW_POWER(low_pwr), .DATA_NOT_READY(dnr), .PRESENCE_N(pres_n));
  host_model host_u (.clk(clk), .reset_req(reset_req), .read_req(read_req),
    .mod_rst_n(mrst_n), .read_clear(rclr));
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  function automatic logic sig(input int w);
    return (w == 0) ? bus_en : (w == 1) ? low_pwr : dnr;
  endfunction : sig
  task automatic wait_for(input int w, input logic v);
    int i;
    i = 0;
    while (sig(w) !== v)
    begin
      tick(1);
      i++;
      if (i > 400)
      begin
        miscompares++;
        give_verdict();
      end
    end
  endtask : wait_for
  // reading every flag also clears the ready flag through bit 0
  task automatic clear_all();
    read_req <= 8'hFF;
    tick(1);
    read_req <= 8'h00;
    tick(5);
  endtask : clear_all
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    tick(16);
    rstn <= 1'b1;
    tick(2);
    chk("not_ready", 8'h01, {7'h00, dnr});
    wait_for(2, 1'b0);
    tick(3);
    chk("ready_attn", 8'h00, {7'h00, attn_n});
    clear_all();
    chk("released", 8'h01, {7'h00, attn_n});
    foreach (rows[r])
    begin
      mask <= rows[r].m;
      cond <= rows[r].c;
      tick(1);
      cond <= 8'h00;
      tick(4);
      chk("status", rows[r].c, status);
      chk("attn", {7'h00, rows[r].a}, {7'h00, attn_n});
      clear_all();
      chk("cleared", 8'h00, status);
      chk("release", 8'h01, {7'h00, attn_n});
    end
    mask <= 8'h00;
    tick(2);
    read_req <= 8'h02;
    tick(1);
    read_req <= 8'h00;
    cond <= 8'h12;
    tick(1);
    cond <= 8'h00;
    mask <= 8'h10;
    tick(4);
    chk("set_wins", 8'h12, status);
    read_req <= 8'h02;
    tick(1);
    read_req <= 8'h00;
    tick(5);
    chk("masked", 8'h01, {7'h00, attn_n});
    mask <= 8'h00;
    tick(3);
    chk("unmasked", 8'h00, {7'h00, attn_n});
    mask <= 8'h10;
    tick(3);
    chk("remasked", 8'h01, {7'h00, attn_n});
    clear_all();
    sel_n <= 1'b0;
    wait_for(0, 1'b1);
    tick(10);
    sel_n <= 1'b1;
    wait_for(0, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      {lp_req, pdown, povr} <= 3'b100 >> k;
      wait_for(1, 1'b1);
      {lp_req, pdown, povr} <= 3'b000;
      wait_for(1, 1'b0);
      tick(3);
      wait_for(2, 1'b0);
      tick(4);
      clear_all();
    end
    reset_req <= 1'b1;
    tick(1);
    reset_req <= 1'b0;
    tick(100);
    chk("reset_nr", 8'h01, {7'h00, dnr});
    wait_for(2, 1'b0);
    tick(3);
    chk("reset_attn", 8'h00, {7'h00, attn_n});
    chk("presence", 8'h00, {7'h00, pres_n});
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
